// *** pkg/odsc_regs.svh ***
// timing and field constants of the octal driver serial control block
`ifndef ODSC_REGS_SVH
`define ODSC_REGS_SVH

`define ODSC_NUM_OUT 8
`define ODSC_FRAME_BITS 8
`define ODSC_CLK_MHZ 250
// filter time for outputs 1 and 2 fault status, least figure in microseconds
`define ODSC_FILT_US 15
`define ODSC_FILT_CYC (`ODSC_FILT_US * `ODSC_CLK_MHZ)
`define ODSC_CTRL_RST 8'h00

`endif

// *** pkg/odsc_pkg.sv ***
// types of the octal driver serial control block
package odsc_pkg;
    typedef enum logic [1:0] {
        ODSC_IDLE = 2'b01,
        ODSC_XFER = 2'b10
    } odsc_state_t;
endpackage

// *** rtl/odsc_sync.sv ***
// two flip-flop synchroniser for a bus of pin inputs
module odsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } odsc_sync_state_t;

    odsc_sync_state_t s_q;
    odsc_sync_state_t s_d;

    always_comb begin
        s_d.meta = async_i;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.sync;
endmodule

// *** rtl/odsc_filter.sv ***
// persistence filter: output follows input once it has held steady long enough
module odsc_filter #(
    parameter int FILT_CYC = 3750
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic raw_i,
    output logic filt_o
);
    typedef struct packed {
        logic [$clog2(FILT_CYC+1)-1:0] cnt;
        logic filt;
    } odsc_filt_state_t;

    odsc_filt_state_t s_q;
    odsc_filt_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (raw_i == s_q.filt) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == ($clog2(FILT_CYC+1))'(FILT_CYC - 1)) begin
            s_d.cnt = '0;
            s_d.filt = raw_i;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    // reset to high: a healthy output reads high
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q <= '{cnt: '0, filt: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign filt_o = s_q.filt;
endmodule

// *** rtl/odsc_core.sv ***
// serial control and diagnostic core of an eight-channel low-side switch
`include "odsc_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1 - chip-select rising edge copies shift register into output control latches
// R2 - copy only if serial clock count since select fall is nonzero multiple of 8
// R3 - host changes chip select only while serial clock is low
// R4 - outputs 1,2 off only when parallel drive is 1 and serial bit 0
// R5 - outputs 3 to 8 follow their serial control bit
// R6 - outputs 1 to 6: overcurrent sets overload latch, output off at once
// R7 - outputs 7,8: regulate on overcurrent, thermal shutdown sets latch, output off
// R8 - outputs 1,2 status is filtered and held in a fault latch
// R9 - fault latches of outputs 1,2 clear while chip select low
// R10 - host trusts the second status read after a fault
// R11 - on output above threshold reads low status (overcurrent case)
// R12 - off output reads high above threshold, low below
// R13 - outputs 3 to 8 status goes straight to the shift register
// R14 - outputs 7,8 on and above threshold read low status
// R15 - chip-select fall parallel-loads all status bits into the shift register
// R16 - while selected, next bit appears on data out at each rising serial clock
// R17 - data in shifted in on each falling serial clock while selected
// R18 - data out released to high impedance after chip select returns high
// R19 - internal reset is external clear pin or undervoltage, either asserts it
// R20 - internal reset clears control and overload latches, all outputs off; outputs 1,2 here still turn on while parallel drive is 0
// R21 - bit for output n sits at shift position n, most significant first
module odsc_core
    import odsc_pkg::*;
#(
    parameter int NUM_OUT = `ODSC_NUM_OUT,
    parameter int FILT_CYC = `ODSC_FILT_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic select_low_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic parallel_drive_one_n_i,
    input wire logic parallel_drive_two_n_i,
    input wire logic external_clear_n_i,
    input wire logic undervoltage_i,
    input wire logic [NUM_OUT-1:0] overcurrent_i,
    input wire logic [NUM_OUT-1:0] thermal_shutdown_i,
    input wire logic [NUM_OUT-1:0] above_threshold_i,
    output logic [NUM_OUT-1:0] out_on_o,
    output logic [NUM_OUT-1:0] regulate_o,
    output logic [NUM_OUT-1:0] overload_o,
    output logic [NUM_OUT-1:0] ctrl_latch_o
);
    // outputs 1 to 6 trip on overcurrent, the rest regulate; outputs 1 and 2 are filtered
    localparam int NUM_TRIP = 6;
    localparam int NUM_FILT = 2;

    typedef struct packed {
        odsc_state_t st;
        logic sclk_prev;
        logic [2:0] bit_cnt;
        logic any_clk;
        logic [NUM_OUT-1:0] shreg;
        logic [NUM_OUT-1:0] ctrl;
        logic [NUM_OUT-1:0] ovl;
        logic [1:0] fault;
        logic sdo;
        logic sdo_oe;
    } odsc_core_state_t;

    odsc_core_state_t s_q;
    odsc_core_state_t s_d;

    // all latches clear and the serial side idle; shared by pin clear and undervoltage
    localparam odsc_core_state_t RST_STATE = '{
        st: ODSC_IDLE,
        sclk_prev: 1'b0,
        bit_cnt: 3'h0,
        any_clk: 1'b0,
        shreg: '0,
        ctrl: NUM_OUT'(`ODSC_CTRL_RST),
        ovl: '0,
        fault: 2'b00,
        sdo: 1'b0,
        sdo_oe: 1'b0
    };

    logic cs_n;
    logic sclk;
    logic sdi;
    logic pd1_n;
    logic pd2_n;
    logic ext_clr_n;
    logic [NUM_OUT-1:0] oc;
    logic [NUM_OUT-1:0] ts;
    logic [NUM_OUT-1:0] above;
    logic int_rst;
    logic [NUM_OUT-1:0] want_on;
    logic [NUM_OUT-1:0] drive_on;
    logic [NUM_OUT-1:0] status;
    logic [1:0] filt_st;
    logic [2:0] link_w;
    logic [2:0] ctl_w;
    logic [NUM_OUT-1:0] ovl_set;
    logic [NUM_OUT-1:0] status_on;
    logic [NUM_OUT-1:0] status_off;
    logic [NUM_OUT-1:0] load;
    logic [1:0] fault_set;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_ok;
    logic [NUM_OUT-1:0] rx_word;

    ////////////////////////////////////////////////////////////////////////////
    // all pins pass two flip-flops before use
    // clock and data share one synchroniser so their relative timing survives it
    odsc_sync #(
        .WIDTH(3)
    ) u_sync_link (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({select_low_i, sclk_i, sdi_i}),
        .sync_o(link_w)
    );

    // the clear reads asserted until the stages fill, which also masks a false select
    odsc_sync #(
        .WIDTH(3)
    ) u_sync_ctl (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({parallel_drive_one_n_i, parallel_drive_two_n_i, external_clear_n_i}),
        .sync_o(ctl_w)
    );

    odsc_sync #(
        .WIDTH(NUM_OUT)
    ) u_sync_oc (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(overcurrent_i),
        .sync_o(oc)
    );

    odsc_sync #(
        .WIDTH(NUM_OUT)
    ) u_sync_ts (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(thermal_shutdown_i),
        .sync_o(ts)
    );

    odsc_sync #(
        .WIDTH(NUM_OUT)
    ) u_sync_above (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(above_threshold_i),
        .sync_o(above)
    );

    assign {cs_n, sclk, sdi} = link_w;
    assign {pd1_n, pd2_n, ext_clr_n} = ctl_w;

    // undervoltage comes from on-chip logic on this clock, no synchroniser
    assign int_rst = sys_rst_i | ~ext_clr_n | undervoltage_i; // see R19

    ////////////////////////////////////////////////////////////////////////////
    // output drive and protection
    always_comb begin
        want_on = s_q.ctrl; // see R5
        // off only for drive 1 with serial bit 0
        want_on[0] = ~(pd1_n & ~s_q.ctrl[0]); // see R4
        want_on[1] = ~(pd2_n & ~s_q.ctrl[1]); // see R4
    end

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            if (g < NUM_TRIP) begin : g_trip
                // synchronised overcurrent gates the output combinationally beside the latch, no cycle of it slips through
                assign drive_on[g] = want_on[g] & ~s_q.ovl[g] & ~oc[g]; // see R6
                assign ovl_set[g] = oc[g]; // see R6
                assign regulate_o[g] = 1'b0;
            end else begin : g_reg
                // lamp loads ride out inrush in regulation; only overtemperature trips them
                assign drive_on[g] = want_on[g] & ~s_q.ovl[g] & ~ts[g]; // see R7
                assign ovl_set[g] = ts[g]; // see R7
                assign regulate_o[g] = drive_on[g] & oc[g]; // see R7
            end
            // on: above threshold means overcurrent or regulation, reads low
            assign status_on[g] = ~above[g]; // see R11 R14
            // off: below threshold means open load or short to ground, reads low
            assign status_off[g] = above[g]; // see R12
            // a tripped output is off, yet its reading stays low until re-armed
            assign status[g] = ~s_q.ovl[g] & (drive_on[g] ? status_on[g] : status_off[g]); // see R11
        end
        for (g = 0; g < NUM_FILT; g++) begin : g_filt
            odsc_filter #(
                .FILT_CYC(FILT_CYC)
            ) u_filt (
                .clk_i(clk_i),
                .sys_rst_i(int_rst),
                .raw_i(status[g]),
                .filt_o(filt_st[g])
            );
            assign fault_set[g] = ~filt_st[g]; // see R8
            // the latch pins a low reading until a frame has carried it out
            assign load[g] = ~s_q.fault[g] & filt_st[g]; // see R8
        end
        for (g = NUM_FILT; g < NUM_OUT; g++) begin : g_direct
            assign load[g] = status[g]; // see R13
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // serial frame state
    // serial clock edges as seen after the synchroniser
    assign sclk_rise = sclk & ~s_q.sclk_prev;
    assign sclk_fall = ~sclk & s_q.sclk_prev;
    // commit filter: a cut frame or a stray clock leaves the outputs alone
    assign frame_ok = s_q.any_clk && (s_q.bit_cnt == 3'h0); // see R2
    // first bit shifted in belongs to output 1
    assign rx_word = {<<{s_q.shreg}}; // see R21

    always_comb begin
        s_d = s_q;
        s_d.sclk_prev = sclk;
        // fault latch: a low (fault) status is held until select goes low
        s_d.fault = s_q.fault | fault_set; // see R8
        case (s_q.st)
            ODSC_IDLE: begin
                s_d.sdo_oe = 1'b0; // see R18
                if (!cs_n) begin
                    s_d.st = ODSC_XFER;
                    s_d.shreg = {<<{load}}; // see R15 R21
                    s_d.bit_cnt = 3'h0;
                    s_d.any_clk = 1'b0;
                    s_d.sdo_oe = 1'b1;
                    s_d.sdo = load[0];
                end
            end
            ODSC_XFER: begin
                s_d.fault = 2'b00; // see R9
                if (cs_n) begin
                    s_d.st = ODSC_IDLE;
                    s_d.sdo_oe = 1'b0; // see R18
                    if (frame_ok) begin
                        s_d.ctrl = rx_word; // see R1 R2 R21
                        // a fresh command re-arms the protection of each output that it switches off
                        s_d.ovl = s_q.ovl & rx_word;
                    end
                end else begin
                    if (sclk_rise) begin
                        s_d.sdo = s_q.shreg[NUM_OUT-1]; // see R16
                    end
                    if (sclk_fall) begin
                        s_d.shreg = {s_q.shreg[NUM_OUT-2:0], sdi}; // see R17
                        s_d.bit_cnt = s_q.bit_cnt + 3'h1; // see R2
                        s_d.any_clk = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = ODSC_IDLE;
            end
        endcase
        // a trip in the commit cycle still latches: the set wins over the re-arm
        s_d.ovl = s_d.ovl | ovl_set; // see R6 R7
    end

    // R3 is relied on: select edges never coincide with serial clock edges
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            s_q <= RST_STATE; // see R20
        end else begin
            s_q <= s_d;
        end
    end

    assign out_on_o = drive_on;
    assign overload_o = s_q.ovl;
    assign ctrl_latch_o = s_q.ctrl;
    assign sdo_o = s_q.sdo;
    assign sdo_oe_o = s_q.sdo_oe;
endmodule

// *** tb/odsc_core_asserts.sv ***
// port-level checks of the serial control core
module odsc_core_asserts #(
    parameter int NUM_OUT = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic select_low_i,
    input wire logic parallel_drive_one_n_i,
    input wire logic external_clear_n_i,
    input wire logic undervoltage_i,
    input wire logic [NUM_OUT-1:0] overcurrent_i,
    input wire logic [NUM_OUT-1:0] thermal_shutdown_i,
    input wire logic sdo_oe_o,
    input wire logic [NUM_OUT-1:0] out_on_o,
    input wire logic [NUM_OUT-1:0] regulate_o,
    input wire logic [NUM_OUT-1:0] overload_o,
    input wire logic [NUM_OUT-1:0] ctrl_latch_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // pins pass a 2-stage sync, hence the 4-cycle windows
    wire logic run = external_clear_n_i && !undervoltage_i;
    uv_clears_a: assert property (undervoltage_i |=> ctrl_latch_o == '0 && overload_o == '0)
        else $error("undervoltage left latches set");
    pin_clears_a: assert property (!external_clear_n_i [*4] |-> ctrl_latch_o == '0)
        else $error("clear pin left control set");
    overload_off_a: assert property ((overload_o & out_on_o) == '0)
        else $error("overloaded output driven");
    sdo_release_a: assert property (select_low_i [*4] |-> !sdo_oe_o)
        else $error("data out not released");
    sdo_drive_a: assert property ((!select_low_i && run) [*4] |-> sdo_oe_o)
        else $error("data out not driven");
    ctrl_hold_a: assert property ((select_low_i && run) [*6] |-> $stable(ctrl_latch_o))
        else $error("control changed while idle");
    drive_off_a: assert property ((parallel_drive_one_n_i && !ctrl_latch_o[0]) [*4] |-> !out_on_o[0])
        else $error("output one not off");
    regulate_a: assert property ((overcurrent_i[6] && !thermal_shutdown_i[6] && ctrl_latch_o[6] && run) [*4]
        |-> regulate_o[6] && out_on_o[6])
        else $error("output seven not regulating");
endmodule

// *** tb/odsc_host_model.sv ***
// serial host model: select, clock and data into the core
module odsc_host_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic select_low_o,
    output logic sclk_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        select_low_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    task automatic half();
        repeat (8) @(posedge clk_i);
        #1;
    endtask
    // serial clock rests low outside frames; select moves only then
    task automatic frame(input int n, input logic [15:0] din, output logic [15:0] dout);
        dout = '0;
        half();
        select_low_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            half();
            sclk_o = 1'b1;
            // frames longer than the pattern repeat it
            sdi_o = din[i % 16];
            half();
            dout[i % 16] = sdo_i;
            sclk_o = 1'b0;
        end
        half();
        select_low_o = 1'b1;
        sdi_o = ~sdi_o;  // released data line must not keep its last level
    endtask
endmodule

// *** tb/odsc_core_tb.sv ***
// self-checking bench of the serial control core
module odsc_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic p1_n = 1'b1, p2_n = 1'b1, clr_n = 1'b1, uv = 1'b0;
    logic [7:0] oc = '0, th = '0, above = '0;
    logic select_low, sclk, sdi, sdo, sdo_oe;
    logic [7:0] on_o, reg_o, ovl_o, ctrl_o, ctrl_exp, s;
    logic [15:0] dout, d;
    logic [31:0] seed = 32'h0205;
    logic [31:0] r;
    int tbl[6] = '{8, 16, 5, 0, 9, 24};
    int n;
    int fail_count = 0;
    int n_tests = 0;
    always #2 clk_i = ~clk_i;
    odsc_host_model i_host (.clk_i(clk_i), .sdo_i(sdo_oe ? sdo : 1'bz), .select_low_o(select_low),
        .sclk_o(sclk), .sdi_o(sdi));
    odsc_core #(.FILT_CYC(4)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .select_low_i(select_low),
        .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .parallel_drive_one_n_i(p1_n),
        .parallel_drive_two_n_i(p2_n), .external_clear_n_i(clr_n), .undervoltage_i(uv), .overcurrent_i(oc),
        .thermal_shutdown_i(th), .above_threshold_i(above), .out_on_o(on_o), .regulate_o(reg_o),
        .overload_o(ovl_o), .ctrl_latch_o(ctrl_o));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // first bit on the wire belongs to output one
    function automatic logic [7:0] rev8(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic send(input int k, input logic [15:0] v);
        i_host.frame(k, v, dout);
        tick(6);
        s = rev8(dout[7:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end
    initial begin
        tick(4);
        sys_rst_i = 1'b0;
        tick(4);
        ctrl_exp = 8'h00;
        for (int i = 0; i < 12; i++) begin
            r = xs();
            n = tbl[i % 6];
            d = r[15:0];
            p1_n = r[16];
            p2_n = r[17];
            send(n, d);
            if (n != 0 && n % 8 == 0) ctrl_exp = rev8(d[7:0]);
            chk("ctrl", ctrl_exp, ctrl_o);
            chk("on", {ctrl_exp[7:2], ~(p2_n & ~ctrl_exp[1]), ~(p1_n & ~ctrl_exp[0])}, on_o);
            p1_n = 1'b1;
            p2_n = 1'b1;
            above = r[31:24];
            // the latch may still hold a fault seen while switching off
            repeat (3) send(8, 16'h0000);
            ctrl_exp = 8'h00;
            chk("status", above, s);
            $display("done random frame %0d", i);
        end
        // a one-cycle dip on output one must not reach its fault latch
        above = 8'h01;
        send(8, 16'h0000);
        above = 8'h00;
        tick(1);
        above = 8'h01;
        tick(8);
        send(8, 16'h0000);
        chk("filter", 8'h01, s & 8'h01);
        $display("done filter");
        send(8, {8'h00, rev8(8'h44)});
        oc = 8'h44;
        tick(8);
        chk("overload", 8'h04, ovl_o);
        chk("regulate", 8'h40, reg_o);
        chk("on", 8'h40, on_o & 8'h44);
        th = 8'h40;
        tick(8);
        chk("overload", 8'h44, ovl_o);
        repeat (2) send(8, {8'h00, rev8(8'h44)});
        chk("status", 8'h00, s & 8'h44);
        oc = 8'h00;
        th = 8'h00;
        $display("done overload");
        for (int k = 0; k < 2; k++) begin
            send(8, 16'h00ff);
            chk("ctrl", 8'hff, ctrl_o);
            clr_n = k[0];
            uv = k[0];
            tick(4);
            clr_n = 1'b1;
            uv = 1'b0;
            tick(4);
            chk("ctrl", 8'h00, ctrl_o);
            chk("overload", 8'h00, ovl_o);
            $display("done clear %0d", k);
        end
        complete_run();
    end
endmodule
bind odsc_core odsc_core_asserts #(.NUM_OUT(NUM_OUT)) i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .select_low_i(select_low_i), .parallel_drive_one_n_i(parallel_drive_one_n_i),
    .external_clear_n_i(external_clear_n_i), .undervoltage_i(undervoltage_i), .overcurrent_i(overcurrent_i),
    .thermal_shutdown_i(thermal_shutdown_i), .sdo_oe_o(sdo_oe_o), .out_on_o(out_on_o),
    .regulate_o(regulate_o), .overload_o(overload_o), .ctrl_latch_o(ctrl_latch_o));
